// [endpoint_command.sv]
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
// Functional notes
// - With the toggle bit set, an interrupt-IN endpoint advances its data PID even when no handshake comes back.
// - A zero-length reception stores the receiving endpoint number in read-only bits 11 to 8.
// - That stored number holds until the next zero-length reception or a hardware reset.
// - Every zero-length reception overwrites the stored number; a single status bit 0 flags that a reception arrived.
// - Bits 7 to 4 are a read/write field that picks the endpoint a command acts on.
// - Bits 3 to 0 carry the command; code 1 ends the setup stage and code 2 forces the next PID to DATA0.
// - Code 3 resets, 4 halts, 5 invalidates, 7 turns off and 8 turns on the chosen endpoint.
// - Code 9 invalidates all, A is USB ready, B setup received, C end of packet, D FIFO clear, E zero-length send.
module endpoint_command
    import epcmd_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic             IRQ,
    input  wire logic        ZLP_RX,
    input  wire logic [3:0]  ZLP_EP,
    input  wire logic        IN_DONE,
    input  wire logic [3:0]  IN_EP,
    input  wire logic        IN_ACK,
    input  wire logic        IN_INTR,
    output logic             CMD_PULSE,
    output logic      [3:0]  CMD_CODE,
    output logic      [3:0]  CMD_EP,
    output logic      [15:0] ENDPOINT_ENABLED,
    output logic      [15:0] ENDPOINT_HALTED,
    output logic      [15:0] PID_STATE
);

    function automatic logic is_reserved(input logic [3:0] code);
        is_reserved = (code == CODE_RSVD0) || (code == CODE_RSVD6) || (code == CODE_RSVDF);
    endfunction

    function automatic logic [15:0] ep_onehot(input logic [3:0] ep);
        ep_onehot = 16'h0001 << ep;
    endfunction

    // bus slave state
    logic        dp_write_reg;
    logic        dp_write_next;
    logic [7:0]  dp_addr_reg;
    logic [7:0]  dp_addr_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic        hreadyout_reg;
    logic        hresp_reg;

    // command register state
    logic        toggle_on_miss_reg;
    logic        toggle_on_miss_next;
    logic [3:0]  target_endpoint_reg;
    logic [3:0]  target_endpoint_next;
    logic [3:0]  code_reg;
    logic [3:0]  code_next;
    logic [3:0]  zero_length_rx_endpoint_reg;
    logic [3:0]  zero_length_rx_endpoint_next;

    // command outputs and endpoint state
    logic        cmd_pulse_reg;
    logic        cmd_pulse_next;
    logic [3:0]  cmd_code_reg;
    logic [3:0]  cmd_code_next;
    logic [3:0]  cmd_ep_reg;
    logic [3:0]  cmd_ep_next;
    logic [15:0] enabled_reg;
    logic [15:0] enabled_next;
    logic [15:0] halted_reg;
    logic [15:0] halted_next;

    // interrupt state
    logic [2:0]  status_reg;
    logic [2:0]  status_next;
    logic [2:0]  mask_reg;
    logic [2:0]  mask_next;
    logic        irq_reg;
    logic        irq_next;

    logic        addr_phase;
    logic        wr_cmd;
    logic        wr_status;
    logic        wr_mask;
    logic [3:0]  wr_code;
    logic [3:0]  wr_ep;
    logic        cmd_ok;
    logic        cmd_bad;
    logic        force_zero;
    logic [2:0]  ev_set;

    assign addr_phase = HSEL && HTRANS[1] && HREADY;
    assign wr_cmd     = dp_write_reg && (dp_addr_reg == CMD_OFFSET);
    assign wr_status  = dp_write_reg && (dp_addr_reg == STATUS_OFFSET);
    assign wr_mask    = dp_write_reg && (dp_addr_reg == MASK_OFFSET);
    assign wr_code    = HWDATA[CODE_LSB +: 4];
    assign wr_ep      = HWDATA[TARGET_LSB +: 4];
    assign cmd_ok     = wr_cmd && !is_reserved(wr_code);
    assign cmd_bad    = wr_cmd && is_reserved(wr_code);
    // endpoint reset also restarts the data PID sequence
    assign force_zero = cmd_ok && (wr_code == CODE_FORCE_PID0 || wr_code == CODE_ENDPOINT_RESET);

    // bus slave: zero wait states, read data registered in the address phase
    always_comb begin
        dp_write_next = 1'b0;
        dp_addr_next  = dp_addr_reg;
        hrdata_next   = hrdata_reg;
        if (addr_phase) begin
            dp_write_next = HWRITE && (HSIZE == HSIZE_WORD);
            dp_addr_next  = HADDR[7:0];
            if (!HWRITE) begin
                if (HADDR[7:0] == CMD_OFFSET) begin
                    // upper bits are undefined by contract; zero is a safe choice
                    hrdata_next = {16'h0000, toggle_on_miss_reg, 3'h0,
                                   zero_length_rx_endpoint_reg, target_endpoint_reg, code_reg};
                end else if (HADDR[7:0] == STATUS_OFFSET) begin
                    hrdata_next = {29'h0, status_reg};
                end else if (HADDR[7:0] == MASK_OFFSET) begin
                    hrdata_next = {29'h0, mask_reg};
                end else begin
                    hrdata_next = WORD_RESET;
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            dp_write_reg <= 1'b0;
            dp_addr_reg  <= 8'h00;
            hrdata_reg    <= WORD_RESET;
            // zero wait states and OKAY only, still launched from flops like every other output
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end else begin
            dp_write_reg  <= dp_write_next;
            dp_addr_reg   <= dp_addr_next;
            hrdata_reg    <= hrdata_next;
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end
    end

    // command register and command decode
    always_comb begin
        toggle_on_miss_next          = toggle_on_miss_reg;
        target_endpoint_next         = target_endpoint_reg;
        code_next                    = code_reg;
        zero_length_rx_endpoint_next = zero_length_rx_endpoint_reg;
        cmd_pulse_next               = 1'b0;
        cmd_code_next                = cmd_code_reg;
        cmd_ep_next                  = cmd_ep_reg;
        enabled_next                 = enabled_reg;
        halted_next                  = halted_reg;
        if (ZLP_RX) begin
            zero_length_rx_endpoint_next = ZLP_EP;
        end
        if (wr_cmd) begin
            toggle_on_miss_next  = HWDATA[TOGGLE_BIT];
            target_endpoint_next = wr_ep;
            code_next            = wr_code;
        end
        if (cmd_ok) begin
            cmd_pulse_next = 1'b1;
            cmd_code_next  = wr_code;
            cmd_ep_next    = wr_ep;
            case (wr_code)
                CODE_ENDPOINT_RESET: begin
                    halted_next = halted_reg & ~ep_onehot(wr_ep);
                end
                CODE_EP_HALT: begin
                    halted_next = halted_reg | ep_onehot(wr_ep);
                end
                CODE_EP_OFF: begin
                    enabled_next = enabled_reg & ~ep_onehot(wr_ep);
                end
                CODE_EP_ON: begin
                    enabled_next = enabled_reg | ep_onehot(wr_ep);
                end
                default: begin
                    enabled_next = enabled_reg;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            toggle_on_miss_reg          <= 1'b0;
            target_endpoint_reg         <= FIELD4_RESET;
            code_reg                    <= FIELD4_RESET;
            zero_length_rx_endpoint_reg <= FIELD4_RESET;
            cmd_pulse_reg               <= 1'b0;
            cmd_code_reg                <= FIELD4_RESET;
            cmd_ep_reg                  <= FIELD4_RESET;
            enabled_reg                 <= EP_VEC_RESET;
            halted_reg                  <= EP_VEC_RESET;
        end else begin
            toggle_on_miss_reg          <= toggle_on_miss_next;
            target_endpoint_reg         <= target_endpoint_next;
            code_reg                    <= code_next;
            zero_length_rx_endpoint_reg <= zero_length_rx_endpoint_next;
            cmd_pulse_reg               <= cmd_pulse_next;
            cmd_code_reg                <= cmd_code_next;
            cmd_ep_reg                  <= cmd_ep_next;
            enabled_reg                 <= enabled_next;
            halted_reg                  <= halted_next;
        end
    end

    // interrupts: a new event in the clearing cycle survives the clear
    assign ev_set = {cmd_bad, cmd_ok, ZLP_RX};

    always_comb begin
        status_next = status_reg;
        mask_next   = mask_reg;
        if (wr_status) begin
            status_next = status_reg & ~HWDATA[2:0];
        end
        if (wr_mask) begin
            mask_next = HWDATA[2:0];
        end
        status_next = status_next | ev_set;
        irq_next    = |(status_next & mask_next);
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            status_reg <= EVENT_RESET;
            mask_reg   <= EVENT_RESET;
            irq_reg    <= 1'b0;
        end else begin
            status_reg <= status_next;
            mask_reg   <= mask_next;
            irq_reg    <= irq_next;
        end
    end

    pid_tracker u_pid (
        .clk            (CLK),
        .resetn         (RESETN),
        .in_done        (IN_DONE),
        .in_ep          (IN_EP),
        .in_ack         (IN_ACK),
        .in_intr        (IN_INTR),
        .toggle_on_miss (toggle_on_miss_reg),
        .force_zero     (force_zero),
        .force_ep       (wr_ep),
        .pid_state      (PID_STATE)
    );

    assign HRDATA           = hrdata_reg;
    assign HREADYOUT        = hreadyout_reg;
    assign HRESP            = hresp_reg;
    assign IRQ              = irq_reg;
    assign CMD_PULSE        = cmd_pulse_reg;
    assign CMD_CODE         = cmd_code_reg;
    assign CMD_EP           = cmd_ep_reg;
    assign ENDPOINT_ENABLED = enabled_reg;
    assign ENDPOINT_HALTED  = halted_reg;

    sequence s_force_write;
        wr_cmd && (wr_code == CODE_FORCE_PID0);
    endsequence

    sequence s_force_issue;
        CMD_PULSE && (CMD_CODE == CODE_FORCE_PID0);
    endsequence

    a_zlp_capture: assert property (@(posedge CLK) disable iff (!RESETN)
        ZLP_RX |=> zero_length_rx_endpoint_reg == $past(ZLP_EP))
        else $error("zero-length endpoint not captured");

    a_zlp_hold: assert property (@(posedge CLK) disable iff (!RESETN)
        !ZLP_RX |=> $stable(zero_length_rx_endpoint_reg))
        else $error("zero-length endpoint changed without reception");

    a_zlp_overwrite: assert property (@(posedge CLK) disable iff (!RESETN)
        ZLP_RX ##1 (ZLP_RX && ZLP_EP != zero_length_rx_endpoint_reg)
        |=> zero_length_rx_endpoint_reg != $past(zero_length_rx_endpoint_reg))
        else $error("second zero-length reception did not overwrite");

    a_cmd_target: assert property (@(posedge CLK) disable iff (!RESETN)
        cmd_ok |=> CMD_EP == $past(wr_ep))
        else $error("command endpoint mismatch");

    a_force_pid: assert property (@(posedge CLK) disable iff (!RESETN)
        s_force_write |=> s_force_issue ##0 (PID_STATE[$past(wr_ep)] == 1'b0))
        else $error("force DATA0 command not issued");

    a_halt_cmd: assert property (@(posedge CLK) disable iff (!RESETN)
        (cmd_ok && wr_code == CODE_EP_HALT) |=> ENDPOINT_HALTED[$past(wr_ep)])
        else $error("halt command did not halt endpoint");

    a_off_cmd: assert property (@(posedge CLK) disable iff (!RESETN)
        (cmd_ok && wr_code == CODE_EP_OFF) |=> !ENDPOINT_ENABLED[$past(wr_ep)])
        else $error("off command left endpoint enabled");

    a_reserved_drop: assert property (@(posedge CLK) disable iff (!RESETN)
        cmd_bad |=> !CMD_PULSE && status_reg[EV_BAD_CMD])
        else $error("reserved code was issued");

    a_other_codes: assert property (@(posedge CLK) disable iff (!RESETN)
        (cmd_ok && wr_code >= CODE_INVAL_ALL && wr_code <= CODE_TX_ZERO)
        |=> CMD_PULSE && CMD_CODE == $past(wr_code) && status_reg[EV_CMD])
        else $error("command code not passed on");

    a_reset_clear: assert property (@(posedge CLK)
        !RESETN |-> zero_length_rx_endpoint_reg == 4'h0 && target_endpoint_reg == 4'h0
                    && code_reg == 4'h0 && !toggle_on_miss_reg)
        else $error("command fields not cleared by reset");

endmodule // endpoint_command

// [epcmd_pkg.sv]
package epcmd_pkg;

    localparam int          EP_COUNT          = 16;

    // register byte offsets
    localparam logic [7:0]  CMD_OFFSET        = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET     = 8'h04;
    localparam logic [7:0]  MASK_OFFSET       = 8'h08;

    // endpoint_command field positions
    localparam int          CODE_LSB          = 0;
    localparam int          TARGET_LSB        = 4;
    localparam int          ZLP_EP_LSB        = 8;
    localparam int          TOGGLE_BIT        = 15;

    // reset values
    localparam logic [3:0]  FIELD4_RESET      = 4'h0;
    localparam logic [2:0]  EVENT_RESET       = 3'h0;
    localparam logic [15:0] EP_VEC_RESET      = 16'h0000;
    localparam logic [31:0] WORD_RESET        = 32'h0000_0000;

    // status and mask bit positions
    localparam int          EV_ZLP            = 0;
    localparam int          EV_CMD            = 1;
    localparam int          EV_BAD_CMD        = 2;

    // command codes
    localparam logic [3:0]  CODE_RSVD0        = 4'h0;
    localparam logic [3:0]  CODE_SETUP_FIN    = 4'h1;
    localparam logic [3:0]  CODE_FORCE_PID0   = 4'h2;
    localparam logic [3:0]  CODE_ENDPOINT_RESET     = 4'h3;
    localparam logic [3:0]  CODE_EP_HALT      = 4'h4;
    localparam logic [3:0]  CODE_EP_INVAL     = 4'h5;
    localparam logic [3:0]  CODE_RSVD6        = 4'h6;
    localparam logic [3:0]  CODE_EP_OFF       = 4'h7;
    localparam logic [3:0]  CODE_EP_ON        = 4'h8;
    localparam logic [3:0]  CODE_INVAL_ALL    = 4'h9;
    localparam logic [3:0]  CODE_USB_READY    = 4'ha;
    localparam logic [3:0]  CODE_SETUP_RCVD   = 4'hb;
    localparam logic [3:0]  CODE_EP_EOP       = 4'hc;
    localparam logic [3:0]  CODE_FIFO_CLEAR   = 4'hd;
    localparam logic [3:0]  CODE_TX_ZERO      = 4'he;
    localparam logic [3:0]  CODE_RSVDF        = 4'hf;

    localparam logic [2:0]  HSIZE_WORD        = 3'h2;

endpackage

// [pid_tracker.sv]
`timescale 1ns/10ps
module pid_tracker
    import epcmd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        in_done,
    input  wire logic [3:0]  in_ep,
    input  wire logic        in_ack,
    input  wire logic        in_intr,
    input  wire logic        toggle_on_miss,
    input  wire logic        force_zero,
    input  wire logic [3:0]  force_ep,
    output logic      [15:0] pid_state
);

    logic [15:0] pid_reg;
    logic [15:0] pid_next;

    genvar g;
    generate
        for (g = 0; g < EP_COUNT; g = g + 1) begin : g_ep
            always_comb begin
                pid_next[g] = pid_reg[g];
                // a forced DATA0 beats a toggle in the same cycle
                if (force_zero && force_ep == 4'(g)) begin
                    pid_next[g] = 1'b0;
                end else if (in_done && in_ep == 4'(g)) begin
                    if (in_ack || (in_intr && toggle_on_miss)) begin
                        pid_next[g] = ~pid_reg[g];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pid_reg <= EP_VEC_RESET;
        end else begin
            pid_reg <= pid_next;
        end
    end

    assign pid_state = pid_reg;

    a_miss_toggles: assert property (@(posedge clk) disable iff (!resetn)
        (in_done && !in_ack && in_intr && toggle_on_miss && !force_zero)
        |=> pid_reg[$past(in_ep)] != $past(pid_reg[in_ep]))
        else $error("pid did not advance on missing handshake");

    a_miss_holds: assert property (@(posedge clk) disable iff (!resetn)
        (in_done && !in_ack && !toggle_on_miss && !force_zero)
        |=> $stable(pid_reg))
        else $error("pid advanced without handshake while toggle off");

endmodule // pid_tracker

// [usb_host_model.sv]
`timescale 1ns/10ps
module usb_host_model (
    input  wire logic       clk,
    output logic            zlp_rx,
    output logic [3:0]      zlp_ep,
    output logic            in_done,
    output logic [3:0]      in_ep,
    output logic            in_ack,
    output logic            in_intr
);
    initial begin
        zlp_rx  = 1'b0;
        zlp_ep  = 4'h0;
        in_done = 1'b0;
        in_ep   = 4'h0;
        in_ack  = 1'b0;
        in_intr = 1'b0;
    end

    // released qualifiers show the inverse of their last value, so a design
    // that samples them outside the strobe cannot pass by luck
    task automatic send_zlp(input logic [3:0] ep);
        zlp_rx <= 1'b1;
        zlp_ep <= ep;
        @(posedge clk);
        zlp_rx <= 1'b0;
        zlp_ep <= ~ep;
    endtask

    // two receptions on consecutive edges, the second naming another endpoint
    task automatic send_zlp_pair(input logic [3:0] ep_a, input logic [3:0] ep_b);
        zlp_rx <= 1'b1;
        zlp_ep <= ep_a;
        @(posedge clk);
        zlp_ep <= ep_b;
        @(posedge clk);
        zlp_rx <= 1'b0;
        zlp_ep <= ~ep_b;
    endtask

    task automatic end_in(input logic [3:0] ep, input logic ack, input logic intr);
        in_done <= 1'b1;
        in_ep   <= ep;
        in_ack  <= ack;
        in_intr <= intr;
        @(posedge clk);
        in_done <= 1'b0;
        in_ep   <= ~ep;
        in_ack  <= ~ack;
        in_intr <= ~intr;
    endtask
endmodule // usb_host_model

// [tb_endpoint_command.sv]
`timescale 1ns/10ps
module tb_endpoint_command
    import epcmd_pkg::*;
;
    typedef struct packed {logic [3:0] code; logic [3:0] ep; logic pulse;} row_s;

    logic        clk, resetn, hsel, hwrite, hreadyout, hresp, irq, cmd_pulse;
    logic        zlp_rx, in_done, in_ack, in_intr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  zlp_ep, in_ep, cmd_code, cmd_ep;
    logic [15:0] ep_en, ep_halt, pid, en_exp, halt_exp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          err_total, total_checks, cycles;
    row_s        rows [18] = '{'{4'h8, 4'h3, 1'b1}, '{4'h4, 4'h3, 1'b1}, '{4'h3, 4'h3, 1'b1},
                               '{4'h7, 4'h3, 1'b1}, '{4'h0, 4'h1, 1'b0}, '{4'h1, 4'h2, 1'b1},
                               '{4'h2, 4'h4, 1'b1}, '{4'h5, 4'h5, 1'b1}, '{4'h6, 4'h6, 1'b0},
                               '{4'h9, 4'h7, 1'b1}, '{4'ha, 4'h8, 1'b1}, '{4'hb, 4'h9, 1'b1},
                               '{4'hc, 4'ha, 1'b1}, '{4'hd, 4'hb, 1'b1}, '{4'he, 4'hc, 1'b1},
                               '{4'hf, 4'hf, 1'b0}, '{4'h8, 4'hf, 1'b1}, '{4'h4, 4'h0, 1'b1}};

    endpoint_command i_endpoint_command (
        .CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .IRQ(irq), .ZLP_RX(zlp_rx), .ZLP_EP(zlp_ep), .IN_DONE(in_done), .IN_EP(in_ep),
        .IN_ACK(in_ack), .IN_INTR(in_intr), .CMD_PULSE(cmd_pulse), .CMD_CODE(cmd_code),
        .CMD_EP(cmd_ep), .ENDPOINT_ENABLED(ep_en), .ENDPOINT_HALTED(ep_halt), .PID_STATE(pid));

    usb_host_model i_usb_host_model (
        .clk(clk), .zlp_rx(zlp_rx), .zlp_ep(zlp_ep), .in_done(in_done), .in_ep(in_ep),
        .in_ack(in_ack), .in_intr(in_intr));

    always #4 clk = ~clk;

    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // no wait-state count is assumed: each phase waits for hready, the timeout cuts a hang
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        hsize  <= HSIZE_WORD;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdat = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    initial begin
        clk = 1'b0; resetn = 1'b1; hsel = 1'b0; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0;
        hsize = HSIZE_WORD; hwdata = 32'h0; err_total = 0; total_checks = 0; cycles = 0;
        en_exp = 16'h0000;
        halt_exp = 16'h0000;
        // a reset that falls at time zero can slip past reset processes not yet waiting on it
        #1 resetn = 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        ahb(1'b0, CMD_OFFSET, 32'h0, rd);
        chk("cmd_reset", 32'h0, {16'h0, rd[15:0]});
        ahb(1'b1, 8'h0c, 32'hffffffff, rd);
        ahb(1'b0, 8'h0c, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        for (int i = 0; i < 18; i++) begin
            ahb(1'b1, CMD_OFFSET, {24'h0, rows[i].ep, rows[i].code}, rd);
            #1;
            chk("cmd_pulse", {31'h0, rows[i].pulse}, {31'h0, cmd_pulse});
            if (rows[i].pulse) begin
                chk("cmd_code_ep", {24'h0, rows[i].ep, rows[i].code}, {24'h0, cmd_ep, cmd_code});
                case (rows[i].code)
                    CODE_EP_ON:    en_exp[rows[i].ep] = 1'b1;
                    CODE_EP_OFF:   en_exp[rows[i].ep] = 1'b0;
                    CODE_EP_HALT:  halt_exp[rows[i].ep] = 1'b1;
                    CODE_ENDPOINT_RESET: halt_exp[rows[i].ep] = 1'b0;
                    default: ;
                endcase
            end
            ahb(1'b0, CMD_OFFSET, 32'h0, rd);
            chk("cmd_readback", {24'h0, rows[i].ep, rows[i].code}, {16'h0, rd[15:0]});
            chk("ep_enabled", {16'h0, en_exp}, {16'h0, ep_en});
            chk("ep_halted", {16'h0, halt_exp}, {16'h0, ep_halt});
            ahb(1'b0, STATUS_OFFSET, 32'h0, rd);
            chk("status", {29'h0, ~rows[i].pulse, rows[i].pulse, 1'b0}, {29'h0, rd[2:0]});
            ahb(1'b1, STATUS_OFFSET, 32'h7, rd);
        end
        // zero-length capture with the interrupt masked in, then out
        ahb(1'b1, MASK_OFFSET, 32'h1, rd);
        i_usb_host_model.send_zlp(4'h5);
        repeat (2) @(posedge clk);
        #1;
        chk("irq_set", 32'h1, {31'h0, irq});
        ahb(1'b1, CMD_OFFSET, 32'h0000_0a21, rd);
        ahb(1'b0, CMD_OFFSET, 32'h0, rd);
        chk("zlp_ep_hold", 32'h5, {28'h0, rd[11:8]});
        ahb(1'b1, STATUS_OFFSET, 32'h7, rd);
        repeat (2) @(posedge clk);
        #1;
        chk("irq_clear", 32'h0, {31'h0, irq});
        ahb(1'b1, MASK_OFFSET, 32'h0, rd);
        i_usb_host_model.send_zlp(4'h9);
        repeat (2) @(posedge clk);
        #1;
        chk("irq_masked", 32'h0, {31'h0, irq});
        ahb(1'b0, CMD_OFFSET, 32'h0, rd);
        chk("zlp_ep_new", 32'h9, {28'h0, rd[11:8]});
        i_usb_host_model.send_zlp_pair(4'h3, 4'hc);
        ahb(1'b0, CMD_OFFSET, 32'h0, rd);
        chk("zlp_ep_pair", 32'hc, {28'h0, rd[11:8]});
        // missed handshake on interrupt-IN, with and without the toggle bit
        ahb(1'b1, CMD_OFFSET, 32'h0000_8012, rd);
        i_usb_host_model.end_in(4'h1, 1'b0, 1'b1);
        @(posedge clk);
        #1;
        chk("pid_miss_on", 32'h1, {31'h0, pid[1]});
        i_usb_host_model.end_in(4'h1, 1'b0, 1'b0);
        @(posedge clk);
        #1;
        chk("pid_bulk_miss", 32'h1, {31'h0, pid[1]});
        ahb(1'b1, CMD_OFFSET, 32'h0000_0012, rd);
        repeat (2) @(posedge clk);
        #1;
        chk("pid_forced", 32'h0, {31'h0, pid[1]});
        i_usb_host_model.end_in(4'h1, 1'b0, 1'b1);
        @(posedge clk);
        #1;
        chk("pid_miss_off", 32'h0, {31'h0, pid[1]});
        i_usb_host_model.end_in(4'h1, 1'b1, 1'b1);
        @(posedge clk);
        #1;
        chk("pid_ack", 32'h1, {31'h0, pid[1]});
        // second reset in mid-run clears the captured endpoint and state
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        chk("state_reset", 32'h0, {pid, ep_en});
        resetn <= 1'b1;
        @(posedge clk);
        ahb(1'b0, CMD_OFFSET, 32'h0, rd);
        chk("cmd_rereset", 32'h0, {16'h0, rd[15:0]});
        ahb(1'b0, STATUS_OFFSET, 32'h0, rd);
        chk("status_rereset", 32'h0, {29'h0, rd[2:0]});
        give_verdict();
    end
endmodule // tb_endpoint_command
